// >>> audio_route_config_bank.sv
/*
 * Serial configuration bank: receives 24-bit frames on the serial port,
 * keeps the first word in a holding register and commits both words to
 * the live settings on a second-word load when slave select rises.
 * Assumes the serial pins are asynchronous to clk_sys and that the serial
 * clock is much slower than clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module audio_route_config_bank (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        sclk,
    input  wire logic        ss_n,
    input  wire logic        mosi,
    output logic             master_power,
    output logic [15:0]      first_word_live,
    output logic [15:0]      second_word_live,
    output logic [15:0]      first_word_applied,
    output logic             gain_amp_powerdown,
    output logic             lowpass_powerdown,
    output logic [1:0]       rate_sel,
    output logic [15:0]      sample_rate_hz,
    output logic [15:0]      passband_hz,
    output logic             filter_src_sel,
    output logic [1:0]       mixer_b_ctl,
    output logic [1:0]       mixer_a_ctl,
    output logic [1:0]       mixer_a_src,
    output logic             mixer_a_src_unused,
    output logic [2:0]       atten,
    output logic [4:0]       atten_db,
    output logic [1:0]       level_src
);
    logic [2:0]  pin_lvl;
    logic [2:0]  pin_rise;
    logic [2:0]  pin_fall;

    logic [23:0] shift_q;
    logic [4:0]  bit_cnt_q;
    logic [15:0] hold_q;
    logic [15:0] live_first_q;
    logic [15:0] live_second_q;
    logic        power_q;
    logic [15:0] eff_first_q;
    logic [15:0] eff_second_q;
    logic [15:0] rate_hz_q;
    logic [15:0] pass_hz_q;

    pin_filter #(
        .W (3)
    ) u_pins (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .pin_in  ({mosi, sclk, ss_n}),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    wire        ss_low     = ~pin_lvl[0];
    wire        ss_start   = pin_fall[0];
    wire        ss_end     = pin_rise[0];
    wire        sclk_edge  = pin_rise[1] & ss_low;
    wire        mosi_lvl   = pin_lvl[2];
    wire        cnt_full   = (bit_cnt_q == 5'(audio_route_pkg::FRAME_BITS));
    wire        frame_ok   = ss_end & cnt_full;
    wire [15:0] frame_data = shift_q[audio_route_pkg::WORD_W-1:0];
    // Frames of any other length are dropped whole rather than half-applied.
    wire        load_first  = frame_ok & shift_q[audio_route_pkg::CTL_LOAD_1ST];
    wire        load_second = frame_ok & shift_q[audio_route_pkg::CTL_LOAD_2ND];
    wire        set_power   = frame_ok;
    wire        power_bit   = shift_q[audio_route_pkg::CTL_POWER];

    // Serial frames arrive least significant bit first.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_q   <= 24'h000000;
            bit_cnt_q <= 5'h00;
        end else if (ce) begin
            if (ss_start) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_edge) begin
                shift_q   <= {mosi_lvl, shift_q[23:1]};
                bit_cnt_q <= (bit_cnt_q == 5'h1f) ? bit_cnt_q : bit_cnt_q + 5'h01;
            end
        end
    end

    // Loads are taken regardless of master power.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hold_q <= audio_route_pkg::FIRST_RST;
        end else if (ce && load_first) begin
            hold_q <= frame_data;
        end
    end

    // The holding register commits with the second word, so the host must
    // send the first word earlier to have both apply together.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            live_first_q  <= audio_route_pkg::FIRST_RST;
            live_second_q <= audio_route_pkg::SECOND_RST;
        end else if (ce && load_second) begin
            live_second_q <= frame_data;
            live_first_q  <= hold_q;
        end
    end

    // Commit happens on the slave select rise, never mid-frame.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            power_q <= 1'b0;
        end else if (ce && set_power) begin
            power_q <= power_bit;
        end
    end

    // While unpowered every stage shows powered down.
    wire [15:0] eff_first_d  = power_q ? live_first_q : audio_route_pkg::FIRST_OFF;
    wire [15:0] eff_second_d = power_q ? live_second_q : audio_route_pkg::SECOND_OFF;
    wire [1:0]  rate_d       = eff_second_d[audio_route_pkg::RATE_LSB +: 2];
    wire [15:0] rate_hz_d    = (rate_d == 2'h0) ? audio_route_pkg::RATE_HZ_0 :
                               (rate_d == 2'h1) ? audio_route_pkg::RATE_HZ_1 :
                               (rate_d == 2'h2) ? audio_route_pkg::RATE_HZ_2 :
                                                  audio_route_pkg::RATE_HZ_3;
    wire [15:0] pass_hz_d    = (rate_d == 2'h0) ? audio_route_pkg::PASS_HZ_0 :
                               (rate_d == 2'h1) ? audio_route_pkg::PASS_HZ_1 :
                               (rate_d == 2'h2) ? audio_route_pkg::PASS_HZ_2 :
                                                  audio_route_pkg::PASS_HZ_3;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            eff_first_q  <= audio_route_pkg::FIRST_OFF;
            eff_second_q <= audio_route_pkg::SECOND_OFF;
            rate_hz_q    <= audio_route_pkg::RATE_HZ_0;
            pass_hz_q    <= audio_route_pkg::PASS_HZ_0;
        end else if (ce) begin
            eff_first_q  <= eff_first_d;
            eff_second_q <= eff_second_d;
            rate_hz_q    <= rate_hz_d;
            pass_hz_q    <= pass_hz_d;
        end
    end

    assign master_power       = power_q;
    assign first_word_live    = live_first_q;
    assign second_word_live   = live_second_q;
    assign first_word_applied = eff_first_q;
    assign gain_amp_powerdown = eff_second_q[audio_route_pkg::GAIN_PD_BIT];
    assign lowpass_powerdown  = eff_second_q[audio_route_pkg::LP_PD_BIT];
    assign rate_sel           = eff_second_q[audio_route_pkg::RATE_LSB +: 2];
    assign sample_rate_hz     = rate_hz_q;
    assign passband_hz        = pass_hz_q;
    assign filter_src_sel     = eff_second_q[audio_route_pkg::FSRC_BIT];
    assign mixer_b_ctl        = eff_second_q[audio_route_pkg::MIXB_LSB +: 2];
    assign mixer_a_ctl        = eff_second_q[audio_route_pkg::MIXA_LSB +: 2];
    assign mixer_a_src        = eff_second_q[audio_route_pkg::ASRC_LSB +: 2];
    // The unused source code is passed on, but flagged for the analog side.
    assign mixer_a_src_unused = (mixer_a_src == audio_route_pkg::ASRC_UNUSED);
    assign atten              = eff_second_q[audio_route_pkg::ATTEN_LSB +: 3];
    assign atten_db           = {atten, 2'b00};
    assign level_src          = eff_second_q[audio_route_pkg::LSRC_LSB +: 2];

    a_second_commit: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && load_second |=> live_second_q == $past(frame_data))
        else $error("second word not committed");

    a_first_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && load_second |=> live_first_q == $past(hold_q))
        else $error("holding register not copied on commit");

    a_first_hold_only: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && load_first && !load_second
        |=> hold_q == $past(frame_data) && $stable(live_first_q))
        else $error("first word load touched live settings");

    a_commit_moment: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(live_second_q) |-> $past(ss_end) && $past(ce))
        else $error("live settings changed away from slave select rise");

    a_accept_unpowered: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && load_second && !power_q |=> live_second_q == $past(frame_data))
        else $error("load refused while unpowered");

    a_power_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !power_q |=> eff_second_q == audio_route_pkg::SECOND_OFF
                           && eff_first_q == audio_route_pkg::FIRST_OFF)
        else $error("settings visible while unpowered");

    a_power_show: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && power_q ##1 ce && power_q && $stable(live_second_q)
        |=> eff_second_q == $past(live_second_q))
        else $error("powered settings not shown");

    a_gain_pd: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && power_q && live_second_q[0] |=> gain_amp_powerdown)
        else $error("gain amplifier not powered down");

    a_lowpass_pd: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && power_q && !live_second_q[1] |=> !lowpass_powerdown)
        else $error("lowpass filter not powered up");

    a_rate_table: assert property (@(posedge clk_sys) disable iff (!nrst)
        rate_sel == 2'h1 && $stable(rate_sel) |-> sample_rate_hz == 16'h1900
                                                  && passband_hz == 16'h0a8c)
        else $error("rate code one gives wrong rate");

    a_atten_scale: assert property (@(posedge clk_sys) disable iff (!nrst)
        atten == 3'h7 |-> atten_db == 5'h1c)
        else $error("full attenuation is not 28 dB");

    a_field_route: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && power_q && !load_second
        |=> {level_src, mixer_a_src, mixer_a_ctl, mixer_b_ctl, filter_src_sel} ==
            {$past(live_second_q[15:14]), $past(live_second_q[10:4])})
        else $error("field routing wrong");
endmodule // audio_route_config_bank

`default_nettype wire

// >>> audio_route_pkg.sv
/*
 * Shared constants of the audio route configuration block, plus the
 * pin synchroniser that the register bank instantiates.
 * Assumes a single system clock; the serial port pins are asynchronous.
 */
// Behaviour
// - Second word bit 0 powers down gain amplifier.
// - Second word bit 1 powers down lowpass filter.
// - Bits 3:2 pick sample rate and passband.
// - Bit 4 picks filter mux source.
// - Bits 6:5 steer or power down mixer B.
// - Bits 8:7 steer or power down mixer A.
// - Bits 10:9 pick mixer A source; 11 unused.
// - Bits 13:11 give attenuation of four dB steps.
// - Bits 15:14 pick the level stage source.
// - Second word load goes straight to live settings.
// - New settings apply when slave select rises.
// - First word load only fills holding register.
// - Second word load also commits the holding register.
// - Loads are accepted while master power is off.
// - Settings show only once master power is set.
`timescale 1ns/1ps
`default_nettype none

package audio_route_pkg;
    localparam int          FRAME_BITS   = 24;
    localparam int          CNT_W        = 5;
    localparam int          WORD_W       = 16;
    localparam int          CTL_LSB      = 16;
    // Control byte bit positions within the received frame.
    localparam int          CTL_POWER    = 16;
    localparam int          CTL_LOAD_1ST = 17;
    localparam int          CTL_LOAD_2ND = 18;
    // Second configuration word field positions.
    localparam int          GAIN_PD_BIT  = 0;
    localparam int          LP_PD_BIT    = 1;
    localparam int          RATE_LSB     = 2;
    localparam int          FSRC_BIT     = 4;
    localparam int          MIXB_LSB     = 5;
    localparam int          MIXA_LSB     = 7;
    localparam int          ASRC_LSB     = 9;
    localparam int          ATTEN_LSB    = 11;
    localparam int          LSRC_LSB     = 14;
    localparam logic [1:0]  ASRC_UNUSED  = 2'h3;
    // Patterns shown while master power is off: every stage powered down.
    localparam logic [15:0] SECOND_OFF   = 16'h01e3;
    localparam logic [15:0] FIRST_OFF    = 16'h2421;
    localparam logic [15:0] SECOND_RST   = 16'h01e3;
    localparam logic [15:0] FIRST_RST    = 16'h2421;
    // Sample rate and passband per rate code, in hertz.
    localparam logic [15:0] RATE_HZ_0    = 16'h1f40;
    localparam logic [15:0] RATE_HZ_1    = 16'h1900;
    localparam logic [15:0] RATE_HZ_2    = 16'h14b4;
    localparam logic [15:0] RATE_HZ_3    = 16'h0fa0;
    localparam logic [15:0] PASS_HZ_0    = 16'h0d48;
    localparam logic [15:0] PASS_HZ_1    = 16'h0a8c;
    localparam logic [15:0] PASS_HZ_2    = 16'h08fc;
    localparam logic [15:0] PASS_HZ_3    = 16'h06a4;
endpackage

module pin_filter #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    wire  [W-1:0] agree = ~(s2_q ^ s3_q);

    if (W < 1) begin : g_bad_width
        $error("pin_filter needs at least one pin");
    end

    // A change counts only once the second and third stages agree.
    assign rise  = agree & s3_q & ~lvl_q;
    assign fall  = agree & ~s3_q & lvl_q;
    assign level = lvl_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            lvl_q <= '1;
        end else if (ce) begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (agree & s3_q) | (~agree & lvl_q);
        end
    end
endmodule // pin_filter

`default_nettype wire

// >>> serial_host_model.sv
/*
 * Host model that drives 24-bit frames onto the serial port, LSB first.
 * Assumes clk_sys comes from the bench; the serial clock runs only inside frames.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
    input  wire logic clk_sys,
    output logic      sclk,
    output logic      ss_n,
    output logic      mosi
);
    initial begin
        sclk = 1'b1;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // Six system clocks per half period give the 48 ns serial clock.
    task automatic half_bit();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    task automatic send_frame(input logic [23:0] frame, input int nbits);
        ss_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            half_bit();
            sclk = 1'b0;
            mosi = frame[i];
            half_bit();
            sclk = 1'b1;
        end
        half_bit();
        ss_n = 1'b1;
        // A released data line must not keep showing the last bit.
        mosi = ~mosi;
    endtask
endmodule // serial_host_model

`default_nettype wire

// >>> audio_route_config_bank_tb_top.sv
/*
 * Self-checking bench of the configuration bank with a serial host model.
 * Assumes the bank shows new live and applied words within six clocks of slave select rising.
 */
`timescale 1ns/1ps
`default_nettype none

module audio_route_config_bank_tb_top;
    logic        clk_sys, nrst, ce, sclk, ss_n, mosi, master_power;
    logic [15:0] first_word_live, second_word_live, first_word_applied;
    logic        gain_amp_powerdown, lowpass_powerdown, filter_src_sel, mixer_a_src_unused;
    logic [1:0]  rate_sel, mixer_b_ctl, mixer_a_ctl, mixer_a_src, level_src;
    logic [15:0] sample_rate_hz, passband_hz;
    logic [2:0]  atten;
    logic [4:0]  atten_db;
    int          bad_count, total_checks;
    logic [15:0] hold_m, first_m, second_m, w;
    logic        pwr_m;

    audio_route_config_bank audio_route_config_bank_i (
        .clk_sys            (clk_sys),
        .nrst               (nrst),
        .ce                 (ce),
        .sclk               (sclk),
        .ss_n               (ss_n),
        .mosi               (mosi),
        .master_power       (master_power),
        .first_word_live    (first_word_live),
        .second_word_live   (second_word_live),
        .first_word_applied (first_word_applied),
        .gain_amp_powerdown (gain_amp_powerdown),
        .lowpass_powerdown  (lowpass_powerdown),
        .rate_sel           (rate_sel),
        .sample_rate_hz     (sample_rate_hz),
        .passband_hz        (passband_hz),
        .filter_src_sel     (filter_src_sel),
        .mixer_b_ctl        (mixer_b_ctl),
        .mixer_a_ctl        (mixer_a_ctl),
        .mixer_a_src        (mixer_a_src),
        .mixer_a_src_unused (mixer_a_src_unused),
        .atten              (atten),
        .atten_db           (atten_db),
        .level_src          (level_src)
    );
    serial_host_model serial_host_model_i (.clk_sys(clk_sys), .sclk(sclk), .ss_n(ss_n),
        .mosi(mosi));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    // Rates 8000/6400/5300/4000 Hz and passbands 3400/2700/2300/1700 Hz.
    function automatic logic [15:0] rate_of(input logic [1:0] c);
        logic [15:0] t[4] = '{16'h1f40, 16'h1900, 16'h14b4, 16'h0fa0};
        return t[c];
    endfunction
    function automatic logic [15:0] pass_of(input logic [1:0] c);
        logic [15:0] t[4] = '{16'h0d48, 16'h0a8c, 16'h08fc, 16'h06a4};
        return t[c];
    endfunction

    task automatic check_all();
        logic [15:0] eff;
        eff = pwr_m ? second_m : audio_route_pkg::SECOND_OFF;
        chk("first_live", first_m, first_word_live);
        chk("second_live", second_m, second_word_live);
        chk("power", {15'h0000, pwr_m}, {15'h0000, master_power});
        chk("first_app", pwr_m ? first_m : audio_route_pkg::FIRST_OFF,
            first_word_applied);
        chk("fields", eff, {level_src, atten, mixer_a_src, mixer_a_ctl,
            mixer_b_ctl, filter_src_sel, rate_sel, lowpass_powerdown,
            gain_amp_powerdown});
        chk("atten_db", {11'h000, eff[13:11], 2'h0}, {11'h000, atten_db});
        chk("rate", rate_of(eff[3:2]), sample_rate_hz);
        chk("pass", pass_of(eff[3:2]), passband_hz);
        chk("src_unused", {15'h0000, eff[10:9] == 2'h3},
            {15'h0000, mixer_a_src_unused});
    endtask

    task automatic frame(input logic [15:0] d, input logic p, input logic l1, input logic l2,
                         input int nbits);
        serial_host_model_i.send_frame({5'h00, l2, l1, p, d}, nbits);
        // The pin has only just risen, so the old settings must still stand.
        chk("not_yet", second_m, second_word_live);
        repeat (6) @(posedge clk_sys);
        #1;
        if (nbits == 24) begin
            pwr_m = p;
            if (l2) begin
                first_m = hold_m;
                second_m = d;
            end
            if (l1) hold_m = d;
        end
        check_all();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        logic [15:0] corner[4];
        corner = '{16'h01e3, 16'h00c5, 16'hffff, 16'h0000};
        nrst = 1'b0;
        ce = 1'b1;
        bad_count = 0;
        total_checks = 0;
        pwr_m = 1'b0;
        hold_m = audio_route_pkg::FIRST_RST;
        first_m = audio_route_pkg::FIRST_RST;
        second_m = audio_route_pkg::SECOND_RST;
        void'($urandom(32'h81d4a95f));
        repeat (6) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        @(posedge clk_sys);
        #1;
        check_all();
        $display("test reset done");
        frame(16'($urandom), 1'b0, 1'b1, 1'b0, 24);
        frame(16'($urandom), 1'b0, 1'b0, 1'b1, 24);
        $display("test powered_off_load done");
        frame(16'($urandom), 1'b1, 1'b1, 1'b0, 24);
        frame(16'($urandom), 1'b1, 1'b0, 1'b1, 24);
        $display("test staged_commit done");
        frame(16'($urandom), 1'b1, 1'b1, 1'b1, 23);
        frame(16'($urandom), 1'b1, 1'b1, 1'b1, 24);
        $display("test short_and_both done");
        for (int i = 0; i < 4; i++) begin
            frame(16'h440b, 1'b1, 1'b1, 1'b0, 24);
            frame(corner[i], 1'b1, 1'b0, 1'b1, 24);
        end
        $display("test corner_words done");
        for (int i = 0; i < 8; i++) begin
            w = 16'($urandom);
            w[3:2] = i[1:0];
            frame(16'($urandom), 1'b1, 1'b1, 1'b0, 24);
            frame(w, 1'b1, 1'b0, 1'b1, 24);
        end
        $display("test random_words done");
        frame(16'h0000, 1'b0, 1'b0, 1'b0, 24);
        $display("test power_down done");
        // A whole frame sent while the clock enable is low must leave no trace.
        ce = 1'b0;
        serial_host_model_i.send_frame({5'h00, 1'b1, 1'b1, 1'b1, 16'($urandom)}, 24);
        repeat (6) @(posedge clk_sys);
        #1;
        ce = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        check_all();
        $display("test frozen_frame done");
        nrst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        pwr_m = 1'b0;
        hold_m = audio_route_pkg::FIRST_RST;
        first_m = audio_route_pkg::FIRST_RST;
        second_m = audio_route_pkg::SECOND_RST;
        @(posedge clk_sys);
        #1;
        check_all();
        frame(16'($urandom), 1'b1, 1'b0, 1'b1, 24);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule // audio_route_config_bank_tb_top

`default_nettype wire
